//--- lisp_liu_model.sv
// Behavioural line interface unit answering the serial port
`timescale 1ns/10ps
`default_nettype none
module lisp_liu_model (
  input wire logic sclk_i,
  input wire logic dout_i,
  input wire logic sel1_n_i,
  input wire logic sel2_n_i,
  output logic din_o,
  output logic [15:0] frame_o,
  output logic [1:0] sel_o
);
  logic [7:0] mem [128];
  logic act;
  int cnt;
  assign act = ~(sel1_n_i & sel2_n_i);
  // Known contents so that reads of untouched registers return something
  initial begin
    din_o = 1'b0;
    frame_o = 16'h0000;
    sel_o = 2'b00;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // A new frame restarts the bit count
  always @(posedge act) cnt = 0;
  // Capture on rising clock; a write frame commits after its 16th bit
  always @(posedge sclk_i) if (act) begin
    frame_o[cnt] = dout_i;
    sel_o = {~sel2_n_i, ~sel1_n_i};
    cnt++;
    if (cnt == 16 && !frame_o[0]) mem[frame_o[7:1]] = frame_o[15:8];
  end
  // Read bits after falling clock, LSB first; otherwise a moving pattern
  // so that the device never sees a stale level it could mistake for data
  always @(negedge sclk_i) begin
    if (act && frame_o[0] && cnt >= 8 && cnt < 16) begin
      din_o = mem[frame_o[7:1]][cnt-8];
    end else begin
      din_o = ~din_o;
    end
  end
endmodule : lisp_liu_model
`default_nettype wire

//--- lisp_pkg.sv
// Constants and types shared by the line interface serial port files
`default_nettype none
package lisp_pkg;
  // Register offsets on the processor port
  localparam logic [7:0] LISP_OFS_COMMAND = 8'h22;
  localparam logic [7:0] LISP_OFS_PAYLOAD = 8'h23;
  localparam logic [7:0] LISP_OFS_STATUS = 8'h24;
  localparam logic [7:0] LISP_OFS_SETUP = 8'h25;
  // Field positions
  localparam int LISP_DIR_BIT = 0;
  localparam int LISP_DONE_BIT = 0;
  localparam int LISP_IER_BIT = 0;
  localparam int LISP_RATE_BIT = 6;
  localparam int LISP_CS_BIT = 7;
  // Values after reset
  localparam logic [7:0] LISP_COMMAND_RST = 8'h00;
  localparam logic [7:0] LISP_PAYLOAD_RST = 8'h00;
  localparam logic [7:0] LISP_SETUP_RST = 8'h00;
  // Frame shape: control byte then data byte
  localparam logic [3:0] LISP_LAST_BIT = 4'hf;
  localparam logic [3:0] LISP_FIRST_DATA_BIT = 4'h8;
  // Serial clock rates and the half periods derived from them
  localparam longint LISP_CLK_HZ = 250000000;
  localparam longint LISP_SLOW_HZ = 1024000;
  localparam longint LISP_FAST_HZ = 8192000;
  localparam logic [7:0] LISP_HALF_SLOW_CYC =
    8'(LISP_CLK_HZ / (2 * LISP_SLOW_HZ));
  localparam logic [7:0] LISP_HALF_FAST_CYC =
    8'(LISP_CLK_HZ / (2 * LISP_FAST_HZ));
  // Transfer sequencer states
  typedef enum logic {LISP_IDLE, LISP_SHIFT} lisp_state_t;
endpackage : lisp_pkg
`default_nettype wire

//--- lisp_rate_div.sv
// Serial clock divider with edge pulses for the sequencer
`timescale 1ns/10ps
`default_nettype none
module lisp_rate_div (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  lisp_shift_if.div lnk
);
  import lisp_pkg::*;
  logic [7:0] cnt;
  logic sclk;
  logic rise;
  logic fall;
  wire [7:0] half = lnk.fast ? LISP_HALF_FAST_CYC : LISP_HALF_SLOW_CYC;
  wire wrap = (cnt == half - 8'h01);

  // Idles low and restarts from zero so every frame opens the same way
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !lnk.run) begin
      cnt <= 8'h00;
      sclk <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt <= wrap ? 8'h00 : cnt + 8'h01; // [RQ12]
      sclk <= wrap ? ~sclk : sclk; // [RQ14]
      rise <= wrap && !sclk;
      fall <= wrap && sclk;
    end
  end

  assign lnk.sclk = sclk;
  assign lnk.rise = rise;
  assign lnk.fall = fall;

  // The clock changes only after a full half period of the chosen rate
  half_period_a: assert property ( // [RQ12]
    @(posedge clk_sys_i) disable iff (rst_i)
    lnk.run && $past(lnk.run) && (sclk != $past(sclk))
      |-> $past(cnt) == $past(half) - 8'h01)
    else $error("serial clock half period wrong");
endmodule : lisp_rate_div
`default_nettype wire

//--- lisp_serial_port.sv
// Serial master toward the line interface unit, with its registers
//
// Functional notes
// RQ1 - Command register write starts one transaction
// RQ2 - Write sends control byte then data byte
// RQ3 - Read sends control byte, stores returned byte
// RQ4 - Direction bit first, data bytes LSB first
// RQ5 - Command bit 0: 0 write, 1 read
// RQ6 - Command bits 7..1 hold remote register index
// RQ7 - Complete flag reads clear while busy
// RQ8 - Finish sets flag; interrupt only if enabled
// RQ9 - Reading status clears the complete flag
// RQ10 - Clearing the flag withdraws the interrupt
// RQ11 - Setup bit 7 picks which select goes low
// RQ12 - Setup bit 6 picks 1.024 or 8.192 MHz; divider gives 244 or 30 cycle periods, 1.025 or 8.333 MHz
// RQ13 - Setup bit 0 enables the completion interrupt
// RQ14 - Select low and clock running only during transfer
// RQ15 - Remote captures bits, returns read data clocked
`timescale 1ns/10ps
`default_nettype none
module lisp_serial_port (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic serial_clk_o,
  output logic serial_dout_o,
  input wire logic serial_din_i,
  output logic first_target_select_n_o,
  output logic second_target_select_n_o,
  output logic irq_out_n_o
);
  import lisp_pkg::*;

  lisp_state_t state;
  lisp_state_t next_state;
  logic [7:0] serial_command;
  logic [7:0] serial_payload;
  logic [7:0] serial_port_setup;
  logic [7:0] rx_shift;
  logic [7:0] rdata;
  logic [15:0] tx_shift;
  logic [3:0] bit_cnt;
  logic transfer_complete;
  logic next_complete;
  logic is_read;
  logic fast_lat;
  logic cs1_n;
  logic cs2_n;
  logic irq_n;
  logic din_meta;
  logic din_sync;

  lisp_shift_if shift_bus ();

  lisp_rate_div u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .lnk(shift_bus.div)
  );

  // Processor port decode
  wire wr_cmd = cpu_wr_i && (cpu_addr_i == LISP_OFS_COMMAND);
  wire wr_pay = cpu_wr_i && (cpu_addr_i == LISP_OFS_PAYLOAD);
  wire wr_setup = cpu_wr_i && (cpu_addr_i == LISP_OFS_SETUP);
  wire rd_stat = cpu_rd_i && (cpu_addr_i == LISP_OFS_STATUS);
  wire [7:0] status_word = {7'h00, transfer_complete};
  wire [7:0] rd_word =
    (cpu_addr_i == LISP_OFS_COMMAND) ? serial_command :
    (cpu_addr_i == LISP_OFS_PAYLOAD) ? serial_payload :
    (cpu_addr_i == LISP_OFS_STATUS) ? status_word :
    (cpu_addr_i == LISP_OFS_SETUP) ? serial_port_setup : 8'h00;

  // Sequencing terms; command writes during a frame are ignored
  wire busy = (state == LISP_SHIFT);
  wire start = wr_cmd && !busy; // [RQ1]
  wire last_fall = busy && shift_bus.fall && (bit_cnt == LISP_LAST_BIT);
  wire data_phase = (bit_cnt >= LISP_FIRST_DATA_BIT);
  wire ier = serial_port_setup[LISP_IER_BIT];
  wire [15:0] tx_load = cpu_wdata_i[LISP_DIR_BIT] ?
    {8'h00, cpu_wdata_i} : {serial_payload, cpu_wdata_i}; // [RQ2] [RQ3]

  assign shift_bus.run = busy; // [RQ14]
  assign shift_bus.fast = fast_lat;

  // Finishing beats a same-cycle status read so no completion is lost
  assign next_complete = start ? 1'b0 : // [RQ7]
    last_fall ? 1'b1 : // [RQ8]
    rd_stat ? 1'b0 : transfer_complete; // [RQ9]
  assign next_state = start ? LISP_SHIFT :
    last_fall ? LISP_IDLE : state;

  // Input pin passes two flops before anything looks at it
  always_ff @(posedge clk_sys_i) begin
    din_meta <= serial_din_i;
    din_sync <= din_meta;
  end

  // Sequencer state and completion flag
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= LISP_IDLE;
      transfer_complete <= 1'b0;
    end else begin
      state <= next_state;
      transfer_complete <= next_complete;
    end
  end

  // Command and setup registers; index and direction latched per frame
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      serial_command <= LISP_COMMAND_RST;
      serial_port_setup <= LISP_SETUP_RST;
    end else begin
      if (start) begin
        serial_command <= cpu_wdata_i; // [RQ5] [RQ6]
      end
      if (wr_setup) begin
        serial_port_setup <= cpu_wdata_i;
      end
    end
  end

  // Payload holds write data, or the byte returned by a read
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      serial_payload <= LISP_PAYLOAD_RST;
    end else if (last_fall && is_read) begin
      serial_payload <= rx_shift; // [RQ3]
    end else if (wr_pay && !busy) begin
      serial_payload <= cpu_wdata_i;
    end
  end

  // Frame setup: select, rate and direction frozen for the whole frame
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cs1_n <= 1'b1;
      cs2_n <= 1'b1;
      fast_lat <= 1'b0;
      is_read <= 1'b0;
    end else if (start) begin
      cs1_n <= serial_port_setup[LISP_CS_BIT]; // [RQ11] [RQ14]
      cs2_n <= !serial_port_setup[LISP_CS_BIT]; // [RQ11]
      fast_lat <= serial_port_setup[LISP_RATE_BIT]; // [RQ12]
      is_read <= cpu_wdata_i[LISP_DIR_BIT]; // [RQ5]
    end else if (last_fall) begin
      cs1_n <= 1'b1; // [RQ14]
      cs2_n <= 1'b1;
    end
  end

  // Transmit: new bit after each falling edge, remote samples on rise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_shift <= 16'h0000;
      bit_cnt <= 4'h0;
    end else if (start) begin
      tx_shift <= tx_load; // [RQ4]
      bit_cnt <= 4'h0;
    end else if (busy && shift_bus.fall) begin
      tx_shift <= {1'b0, tx_shift[15:1]}; // [RQ4] [RQ15]
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Receive: sample on each rising edge of the data half, LSB first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_shift <= 8'h00;
    end else if (busy && is_read && data_phase && shift_bus.rise) begin
      rx_shift <= {din_sync, rx_shift[7:1]}; // [RQ4] [RQ15]
    end
  end

  // Interrupt follows the next flag value so clearing drops it promptly
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(next_complete && ier); // [RQ8] [RQ10] [RQ13]
    end
  end

  // Read data port holds its last value between reads
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else if (cpu_rd_i) begin
      rdata <= rd_word;
    end
  end

  assign cpu_rdata_o = rdata;
  assign serial_clk_o = shift_bus.sclk;
  assign serial_dout_o = tx_shift[0];
  assign first_target_select_n_o = cs1_n;
  assign second_target_select_n_o = cs2_n;
  assign irq_out_n_o = irq_n;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start;
    start;
  endsequence
  sequence s_frame_end;
    last_fall;
  endsequence

  start_frame_a: assert property (s_start |=> busy && !transfer_complete) // [RQ1]
    else $error("command write did not start a frame");
  busy_flag_a: assert property (busy |-> !transfer_complete) // [RQ7]
    else $error("complete flag set while busy");
  finish_flag_a: assert property (s_frame_end |=> transfer_complete && !busy) // [RQ8]
    else $error("frame end did not set complete flag");
  irq_raise_a: assert property ((transfer_complete && ier) [*2] // [RQ8]
    |-> !irq_out_n_o)
    else $error("enabled completion gave no interrupt");
  irq_mask_a: assert property (!ier [*2] |-> irq_out_n_o) // [RQ13]
    else $error("interrupt while disabled");
  irq_drop_a: assert property (!transfer_complete |-> irq_out_n_o) // [RQ10]
    else $error("interrupt held after flag cleared");
  stat_clear_a: assert property (rd_stat && !last_fall && !start // [RQ9]
    |=> !transfer_complete)
    else $error("status read did not clear flag");
  which_select_a: assert property ($rose(busy) // [RQ11]
    |-> second_target_select_n_o == !$past(serial_port_setup[7]) &&
        first_target_select_n_o == $past(serial_port_setup[7]))
    else $error("wrong chip select driven");
  idle_pins_a: assert property (!busy |-> first_target_select_n_o && // [RQ14]
    second_target_select_n_o && !serial_clk_o)
    else $error("select or clock active outside a frame");
  first_bit_a: assert property (s_start // [RQ4]
    |=> serial_dout_o == $past(cpu_wdata_i[0]))
    else $error("direction bit not sent first");
  read_store_a: assert property (s_frame_end and is_read // [RQ3]
    |=> serial_payload == $past(rx_shift))
    else $error("read data not stored");
  write_keep_a: assert property (s_frame_end and !is_read // [RQ2]
    |=> serial_payload == $past(serial_payload))
    else $error("write frame altered payload");
endmodule : lisp_serial_port
`default_nettype wire

//--- lisp_serial_port_tb.sv
// Self-checking bench for the line interface serial port
`timescale 1ns/10ps
`default_nettype none
module lisp_serial_port_tb;
  import lisp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sclk, dout, din, sel1_n, sel2_n, irq_n;
  logic [15:0] frame;
  logic [1:0] sel_seen;
  int bad_count = 0;
  int checked = 0;
  realtime last_rise = 0.0;
  realtime per = 0.0;
  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  lisp_serial_port lisp_serial_port_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cpu_addr_i(addr), .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_wdata_i(wdata),
    .cpu_rdata_o(rdata), .serial_clk_o(sclk), .serial_dout_o(dout),
    .serial_din_i(din), .first_target_select_n_o(sel1_n),
    .second_target_select_n_o(sel2_n), .irq_out_n_o(irq_n));
  lisp_liu_model lisp_liu_model_i (.sclk_i(sclk), .dout_i(dout),
    .sel1_n_i(sel1_n), .sel2_n_i(sel2_n), .din_o(din), .frame_o(frame),
    .sel_o(sel_seen));
  // Serial clock period, last value inside a frame is what gets judged
  always @(posedge sclk) begin
    per = $realtime - last_rise;
    last_rise = $realtime;
  end
  task automatic chk(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask : wr_reg
  // Read data is registered, so it is taken half a cycle after the edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // All registers and the unmapped neighbour read zero, pins idle
  task automatic check_reset();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'h22 + 8'(i), v);
      chk("reset read", 16'h0000, {8'h00, v});
    end
    chk("idle pins", 16'h0007, {13'h0, sel2_n, sel1_n, irq_n});
  endtask : check_reset
  // One whole transaction, with a payload write while busy that must vanish
  task automatic xfer(input logic [7:0] setup, input logic [7:0] cmd,
    input logic [7:0] data, input logic [7:0] exp_rd);
    logic [7:0] v;
    logic [7:0] h;
    int n;
    h = setup[LISP_RATE_BIT] ? LISP_HALF_FAST_CYC : LISP_HALF_SLOW_CYC;
    wr_reg(LISP_OFS_SETUP, setup);
    wr_reg(LISP_OFS_PAYLOAD, data);
    wr_reg(LISP_OFS_COMMAND, cmd);
    rd_reg(LISP_OFS_STATUS, v);
    chk("busy status", 16'h0000, {8'h00, v});
    wr_reg(LISP_OFS_PAYLOAD, ~data);
    chk("selects", {14'h0, setup[7] ? 2'b01 : 2'b10},
      {14'h0, sel2_n, sel1_n});
    n = 0;
    while (!(sel1_n === 1'b1 && sel2_n === 1'b1) && n < 5000) begin
      @(negedge clk_sys_i);
      n++;
    end
    // A frame that never ends runs the wait out and counts here
    chk("frame ended", 16'h0001, {15'h0, sel1_n & sel2_n});
    repeat (2) @(negedge clk_sys_i);
    chk("irq", {15'h0, ~setup[0]}, {15'h0, irq_n});
    chk("sclk idle", 16'h0000, {15'h0, sclk});
    chk("frame", {cmd[0] ? 8'h00 : data, cmd}, frame);
    chk("target", {14'h0, setup[7] ? 2'b10 : 2'b01}, {14'h0, sel_seen});
    chk("period", 16'(h) * 16'd8, 16'($rtoi(per)));
    rd_reg(LISP_OFS_STATUS, v);
    chk("done", 16'h0001, {8'h00, v});
    chk("irq cleared", 16'h0001, {15'h0, irq_n});
    rd_reg(LISP_OFS_STATUS, v);
    chk("done cleared", 16'h0000, {8'h00, v});
    rd_reg(LISP_OFS_PAYLOAD, v);
    chk("payload", {8'h00, exp_rd}, {8'h00, v});
    rd_reg(LISP_OFS_COMMAND, v);
    chk("command", {8'h00, cmd}, {8'h00, v});
  endtask : xfer
  // Main sequence: both selects, both rates, interrupt on and off
  initial begin
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    check_reset();
    xfer(8'h01, 8'h2a, 8'ha3, 8'ha3);
    xfer(8'hc0, 8'h2b, 8'h00, 8'ha3);
    xfer(8'h41, 8'h66, 8'h11, 8'h11);
    xfer(8'h80, 8'h0f, 8'h00, 8'h5d);
    summarize();
  end
  // Two slow and two fast frames need under 10000 cycles; ample margin
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    bad_count++;
    summarize();
  end
endmodule : lisp_serial_port_tb
`default_nettype wire

//--- lisp_shift_if.sv
// Link between the transfer sequencer and the serial clock divider
`timescale 1ns/10ps
`default_nettype none
interface lisp_shift_if;
  logic run;
  logic fast;
  logic sclk;
  logic rise;
  logic fall;
  modport div (input run, input fast, output sclk, output rise,
    output fall);
  modport ctl (output run, output fast, input sclk, input rise,
    input fall);
endinterface : lisp_shift_if
`default_nettype wire
